// ===== shared/cdm_cfg.svh
// constants of the clock dropout monitor status block
// assumes 32-bit apb data, byte addresses, one word per register
`ifndef CDM_CFG_SVH
`define CDM_CFG_SVH

// register byte offsets
`define CDM_OFF_STATUS 8'h00
`define CDM_OFF_EVENTS 8'h04
`define CDM_OFF_COUNT 8'h08
`define CDM_OFF_CONFIG 8'h0c
`define CDM_OFF_CONTROL 8'h10

// field positions
`define CDM_STS_LOS_BIT 0
`define CDM_STS_INV_BIT 1
`define CDM_EVT_LOS_BIT 0
`define CDM_EVT_LMT_BIT 1
`define CDM_EVT_NUM 2
`define CDM_CNT_MSB 3
`define CDM_CNT_LSB 0
`define CDM_CFG_THR_MSB 11
`define CDM_CFG_THR_LSB 8
`define CDM_CFG_FMASK_BIT 7
`define CDM_CFG_DIS_BIT 6
`define CDM_CFG_LMASK_BIT 5
`define CDM_CTL_GATE_BIT 0
`define CDM_CTL_SRST_BIT 1

// reset values and counter limits
`define CDM_RST_LOS_STS 1'h1
`define CDM_RST_INVALID 1'h1
`define CDM_RST_EVENTS 2'h1
`define CDM_RST_CNT 4'h0
`define CDM_CNT_MAX 4'hf
`define CDM_CNT_ONE 4'h1
`define CDM_RST_THR 4'h0
`define CDM_RST_BIT 1'h0
`define CDM_ZERO_WORD 32'h0000_0000

`endif

// ===== shared/cdm_pkg.sv
// types of the clock dropout monitor status block
// assumes the constants header is compiled alongside
package cdm_pkg;

    // one apb request as latched in the setup cycle
    typedef struct packed {
        logic [7:0] addr;
        logic write;
        logic [31:0] wdata;
    } cdm_apb_req_t;

    // software configuration of the reference qualification
    typedef struct packed {
        logic [3:0] thresh;
        logic freq_mask;
        logic ref_disable;
        logic los_mask;
    } cdm_cfg_t;

    // monitor control bits
    typedef struct packed {
        logic monitor_soft_reset;
        logic monitor_clock_gate;
    } cdm_ctl_t;

    // phase of the apb slave
    typedef enum logic [0:0] {
        CDM_BUS_IDLE,
        CDM_BUS_ACCESS
    } cdm_bus_st_t;

endpackage

// ===== hdl/cdm_apb_slave.sv
// apb slave front end: zero-wait access phase, latched request
// assumes an apb master on clk_sys; decode and data live in the caller
`timescale 1ns/1ns
module cdm_apb_slave
    import cdm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic setup,
    output logic wr_stb,
    output cdm_apb_req_t req
);
    cdm_bus_st_t st_r;
    cdm_bus_st_t st_nxt;

    // setup cycle seen, access completes on the next edge
    assign setup = psel & ~penable;
    assign wr_stb = (st_r == CDM_BUS_ACCESS) & psel & penable & req.write;
    assign pready = (st_r == CDM_BUS_ACCESS);

    always_comb begin
        case (st_r)
            CDM_BUS_IDLE: st_nxt = setup ? CDM_BUS_ACCESS : CDM_BUS_IDLE;
            CDM_BUS_ACCESS: st_nxt = CDM_BUS_IDLE;
            default: st_nxt = CDM_BUS_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_r <= CDM_BUS_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // request held from setup so the access phase needs no decode of inputs
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            req <= '0;
        end else if (setup) begin
            req <= '{addr: paddr, write: pwrite, wdata: pwdata};
        end
    end
endmodule

// ===== hdl/cdm_sticky_bit.sv
// one sticky event bit, set by a level, cleared by a one-cycle pulse
// assumes set and clear are on clk_sys; set outranks clear
`timescale 1ns/1ns
module cdm_sticky_bit #(
    parameter logic RST_VAL = 1'h0
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic set_lvl,
    input wire logic clr_pls,
    output logic flag
);
    logic flag_r;
    logic flag_nxt;

    // a held condition re-asserts every cycle, so a clear cannot stick
    assign flag_nxt = set_lvl | (flag_r & ~clr_pls);
    assign flag = flag_r;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flag_r <= RST_VAL;
        end else begin
            flag_r <= flag_nxt;
        end
    end
endmodule

// ===== hdl/cdm_top.sv
// clock dropout monitor status, sticky events and failure counter
// assumes the qualification engine and frequency monitor run on clk_sys
// and deliver their verdicts as levels; software talks over apb
//
// What this block does
// (R01) invalid flag when disqualified or inhibited; resets 1
// (R02) dropout status mirrors verdict, resets to 1
// (R03) limit event sets while count above threshold
// (R04) limit clear ignored while count exceeds threshold
// (R05) dropout event sticky, clear ignored during loss
// (R06) dropout event resets 1, software clears later
// (R07) failure counter increments per loss, saturates
// (R08) writing zero clears counter, else presets it
// (R09) counter writes dropped when gated or soft-reset
// (R10) limit compares counter strictly above 4-bit threshold
// (R11) selection inhibit forces invalid flag to one
// (R12) dropout mask removes dropout from invalid flag
// (R13) frequency mask removes frequency fail from flag
// (R14) count rising edges of dropout, not cycles
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "cdm_cfg.svh"
module cdm_top
    import cdm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic los_verdict,
    input wire logic freq_disqualified,
    output logic los_status,
    output logic ref_invalid,
    output logic ref_barred
);

    // address decode helper, used for read and write decode alike;
    // an exact compare, so a misaligned address never aliases a register
    function automatic logic reg_hit(
        input logic [7:0] addr,
        input logic [7:0] offset
    );
        reg_hit = (addr == offset);
    endfunction

    // bus front end
    logic bus_setup;
    logic bus_wr;
    cdm_apb_req_t bus_req;

    cdm_apb_slave u_apb (
        .clk_sys(clk_sys),
        .rst(rst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pready(pready),
        .setup(bus_setup),
        .wr_stb(bus_wr),
        .req(bus_req)
    );

    // monitor-facing state: dropout status, reference flag, failure count
    logic los_sts_r;
    logic ref_invalid_r;
    logic ref_invalid_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;

    // software settings, changed only by bus writes
    cdm_cfg_t cfg_r;
    cdm_cfg_t cfg_nxt;
    cdm_ctl_t ctl_r;
    cdm_ctl_t ctl_nxt;

    // bus answer, registered so it cannot glitch during access
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic pslverr_r;
    logic pslverr_nxt;

    // one bit per event: stored flag, set level, clear pulse
    logic [`CDM_EVT_NUM-1:0] evt_flag;
    logic [`CDM_EVT_NUM-1:0] evt_set;
    logic [`CDM_EVT_NUM-1:0] evt_clr;

    // write decode, effective at the edge that ends the access phase;
    // the latched address is decoded, so a moving paddr cannot retarget it
    wire wr_events = bus_wr & reg_hit(bus_req.addr, `CDM_OFF_EVENTS);
    wire wr_count = bus_wr & reg_hit(bus_req.addr, `CDM_OFF_COUNT);
    wire wr_config = bus_wr & reg_hit(bus_req.addr, `CDM_OFF_CONFIG);
    wire wr_control = bus_wr & reg_hit(bus_req.addr, `CDM_OFF_CONTROL);
    // write data also comes from the latched request
    wire [31:0] wdata = bus_req.wdata;

    // monitor hold: a gated or soft-reset monitor neither counts
    // nor accepts counter writes; status and events keep running so
    // software still sees the verdict while it reprograms the monitor
    wire monitor_held = ctl_r.monitor_clock_gate | ctl_r.monitor_soft_reset;

    // dropout status mirror and loss onset; the verdict is a level
    // from logic on this clock, so it needs no synchroniser
    // status is the verdict one clock later; the onset compares the
    // fresh verdict to that copy, so a long loss gives one pulse
    wire los_rise = los_verdict & ~los_sts_r; // R14

    // status register, one clock behind the verdict
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            los_sts_r <= `CDM_RST_LOS_STS; // R02
        end else begin
            los_sts_r <= los_verdict; // R02
        end
    end

    // reference invalid, registered so the flag never glitches
    // while masks or the inhibit are being rewritten
    // each monitor contributes unless masked; the inhibit overrides
    wire los_term = los_sts_r & ~cfg_r.los_mask; // R12
    wire freq_term = freq_disqualified & ~cfg_r.freq_mask; // R13
    wire inhibit_term = cfg_r.ref_disable; // R11

    // any one contributor makes the reference invalid
    assign ref_invalid_nxt = los_term | freq_term | inhibit_term; // R01

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ref_invalid_r <= `CDM_RST_INVALID; // R01
        end else begin
            ref_invalid_r <= ref_invalid_nxt;
        end
    end

    // failure counter: four bits that stop at the top value, so a
    // long-failing reference cannot wrap back under the threshold
    // a software write wins over a loss onset in the same cycle;
    // the preset is what software asked for, the onset is then lost
    wire cnt_wr_ok = wr_count & ~monitor_held; // R09
    // saturation looks at the stored count, so the top value holds
    wire cnt_sat = (cnt_r == `CDM_CNT_MAX);
    wire cnt_inc = los_rise & ~monitor_held & ~cnt_sat; // R07
    wire [3:0] cnt_wval = wdata[`CDM_CNT_MSB:`CDM_CNT_LSB];

    always_comb begin
        cnt_nxt = cnt_r;
        if (cnt_wr_ok) begin
            cnt_nxt = cnt_wval; // R08
        end else if (cnt_inc) begin
            cnt_nxt = cnt_r + `CDM_CNT_ONE; // R07
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_r <= `CDM_RST_CNT;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // event conditions, given as levels so that a condition which
    // persists keeps re-asserting its sticky bit every cycle
    // the limit test uses the stored count, so a preset above the
    // threshold raises the limit event one clock after the write
    wire lmt_cond = (cnt_r > cfg_r.thresh); // R10

    assign evt_set[`CDM_EVT_LOS_BIT] = los_sts_r; // R05
    assign evt_set[`CDM_EVT_LMT_BIT] = lmt_cond; // R03

    // sticky event bits, write one to clear; a loop keeps every
    // event bit built the same way, each taking its own reset value
    // the set input outranks the clear, so a clear during a standing
    // condition is simply overwritten
    genvar gi;
    generate
        for (gi = 0; gi < `CDM_EVT_NUM; gi++) begin : g_evt
            // each bit takes its own reset value from the packed reset word
            localparam logic RST_VAL = 1'(`CDM_RST_EVENTS >> gi);

            // a one written at this bit position asks for its clear
            assign evt_clr[gi] = wr_events & wdata[gi]; // R04

            // set level and clear pulse meet inside, where the set wins
            cdm_sticky_bit #(
                .RST_VAL(RST_VAL) // R06
            ) u_evt (
                .clk_sys(clk_sys),
                .rst(rst),
                .set_lvl(evt_set[gi]),
                .clr_pls(evt_clr[gi]),
                .flag(evt_flag[gi])
            );
        end
    endgenerate

    // configuration and control registers; each write replaces all
    // fields at once, so no half-updated threshold is ever compared
    always_comb begin
        cfg_nxt = cfg_r;
        if (wr_config) begin
            cfg_nxt.thresh = wdata[`CDM_CFG_THR_MSB:`CDM_CFG_THR_LSB];
            cfg_nxt.freq_mask = wdata[`CDM_CFG_FMASK_BIT];
            cfg_nxt.ref_disable = wdata[`CDM_CFG_DIS_BIT];
            cfg_nxt.los_mask = wdata[`CDM_CFG_LMASK_BIT];
        end
    end

    always_comb begin
        ctl_nxt = ctl_r;
        if (wr_control) begin
            ctl_nxt.monitor_clock_gate = wdata[`CDM_CTL_GATE_BIT];
            ctl_nxt.monitor_soft_reset = wdata[`CDM_CTL_SRST_BIT];
        end
    end

    // configuration store
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cfg_r.thresh <= `CDM_RST_THR;
            cfg_r.freq_mask <= `CDM_RST_BIT;
            cfg_r.ref_disable <= `CDM_RST_BIT;
            cfg_r.los_mask <= `CDM_RST_BIT;
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    // control store; both bits clear so the monitor runs after reset
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctl_r.monitor_clock_gate <= `CDM_RST_BIT;
            ctl_r.monitor_soft_reset <= `CDM_RST_BIT;
        end else begin
            ctl_r <= ctl_nxt;
        end
    end

    // read words; unused bits read as zero so software may
    // compare whole words without masking reserved fields
    logic [31:0] word_status;
    logic [31:0] word_events;
    logic [31:0] word_count;
    logic [31:0] word_config;
    logic [31:0] word_control;

    always_comb begin
        word_status = `CDM_ZERO_WORD;
        word_status[`CDM_STS_LOS_BIT] = los_sts_r; // R02
        word_status[`CDM_STS_INV_BIT] = ref_invalid_r; // R01
    end

    always_comb begin
        word_events = `CDM_ZERO_WORD;
        word_events[`CDM_EVT_NUM-1:0] = evt_flag;
    end

    always_comb begin
        word_count = `CDM_ZERO_WORD;
        word_count[`CDM_CNT_MSB:`CDM_CNT_LSB] = cnt_r;
    end

    always_comb begin
        word_config = `CDM_ZERO_WORD;
        word_config[`CDM_CFG_THR_MSB:`CDM_CFG_THR_LSB] = cfg_r.thresh;
        word_config[`CDM_CFG_FMASK_BIT] = cfg_r.freq_mask;
        word_config[`CDM_CFG_DIS_BIT] = cfg_r.ref_disable;
        word_config[`CDM_CFG_LMASK_BIT] = cfg_r.los_mask;
    end

    always_comb begin
        word_control = `CDM_ZERO_WORD;
        word_control[`CDM_CTL_GATE_BIT] = ctl_r.monitor_clock_gate;
        word_control[`CDM_CTL_SRST_BIT] = ctl_r.monitor_soft_reset;
    end

    // read select on the setup address; capturing the word then keeps
    // it coherent even if a flag changes during the access cycle
    wire rd_status = reg_hit(paddr, `CDM_OFF_STATUS);
    wire rd_events = reg_hit(paddr, `CDM_OFF_EVENTS);
    wire rd_count = reg_hit(paddr, `CDM_OFF_COUNT);
    wire rd_config = reg_hit(paddr, `CDM_OFF_CONFIG);
    wire rd_control = reg_hit(paddr, `CDM_OFF_CONTROL);
    wire addr_mapped = rd_status | rd_events | rd_count | rd_config | rd_control;

    // the selects are one-hot, so an or of masked words is the mux
    wire [31:0] rd_mux =
        ({32{rd_status}} & word_status) |
        ({32{rd_events}} & word_events) |
        ({32{rd_count}} & word_count) |
        ({32{rd_config}} & word_config) |
        ({32{rd_control}} & word_control);

    // read data sampled at the setup edge and held through access;
    // a write reads back zero
    always_comb begin
        prdata_nxt = prdata_r;
        if (bus_setup) begin
            prdata_nxt = pwrite ? `CDM_ZERO_WORD : rd_mux;
        end
    end

    // an unmapped address errors for reads and writes and stores nothing
    always_comb begin
        pslverr_nxt = pslverr_r;
        if (bus_setup) begin
            pslverr_nxt = ~addr_mapped;
        end
    end

    // read data register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prdata_r <= `CDM_ZERO_WORD;
        end else begin
            prdata_r <= prdata_nxt;
        end
    end

    // error flag register, loaded together with the read data
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pslverr_r <= `CDM_RST_BIT;
        end else begin
            pslverr_r <= pslverr_nxt;
        end
    end

    // outputs, all from flip-flops, so no pin has a combinational
    // path back to the bus inputs
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;
    assign los_status = los_sts_r;
    assign ref_invalid = ref_invalid_r;
    assign ref_barred = cfg_r.ref_disable; // R11

endmodule

// ===== tb/cdm_top_assertions.sv
// port-level checker of the dropout monitor status block
// assumes zero-wait apb and same-clock monitor verdicts as levels
`timescale 1ns/1ns
module cdm_top_chk
    import cdm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic los_verdict,
    input wire logic freq_disqualified,
    input wire logic los_status,
    input wire logic ref_invalid,
    input wire logic ref_barred
);
    // one clock domain, so clock and reset are given once
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // bus phases seen at a rising edge
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_rd(logic [7:0] a);
        psel && !penable && !pwrite && paddr == a;
    endsequence

    property p_reset_vals;
        $fell(rst) |-> los_status && ref_invalid && !ref_barred;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("outputs left reset with wrong values");

    property p_los_mirror;
        !$past(rst) |-> los_status == $past(los_verdict);
    endproperty
    a_los_mirror: assert property (p_los_mirror)
        else $error("dropout status does not follow the verdict");

    property p_barred;
        ref_barred |=> ref_invalid;
    endproperty
    a_barred: assert property (p_barred)
        else $error("inhibited reference not flagged invalid");

    property p_clean;
        !ref_barred && !los_status && !freq_disqualified |=> !ref_invalid;
    endproperty
    a_clean: assert property (p_clean)
        else $error("qualified reference flagged invalid");

    property p_status_read;
        s_rd(8'h00) |=> prdata[1:0] == {$past(ref_invalid), $past(los_status)};
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read differs from status pins");

    property p_event_read;
        s_rd(8'h04) ##0 $past(los_status) |=> prdata[0];
    endproperty
    a_event_read: assert property (p_event_read)
        else $error("dropout event not set during loss");

    property p_ready;
        s_setup |=> pready;
    endproperty
    a_ready: assert property (p_ready)
        else $error("no ready in access cycle");

    property p_ready_one;
        pready |=> !pready;
    endproperty
    a_ready_one: assert property (p_ready_one)
        else $error("ready longer than one cycle");

    property p_unmapped;
        s_setup ##0 (paddr > 8'h10) |=> pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access without error");
endmodule

// ===== tb/clock_dropout_monitor_status_test.sv
// self-checking bench of the dropout monitor status block
// assumes the design files and the checker file are compiled first
`timescale 1ns/1ns
`include "cdm_cfg.svh"
module clock_dropout_monitor_status_test
    import cdm_pkg::*;
;
    logic clk_sys, rst, psel, penable, pwrite, los_verdict, freq_disqualified;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic pready, pslverr, los_status, ref_invalid, ref_barred, rerr;
    int err_total, samples_checked;

    cdm_top dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .los_verdict(los_verdict), .freq_disqualified(freq_disqualified), .los_status(los_status),
        .ref_invalid(ref_invalid), .ref_barred(ref_barred));

    task results;
        if (err_total == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one apb transfer, entered and left just after a rising edge
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) err_total++;
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask

    task rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0000_0000);
        chk(nm, exp, rdat & m);
    endtask

    task cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // masks only take contributors away; the inhibit forces invalid
    function logic f_invalid(input logic l, input logic f, input logic [2:0] m);
        return m[1] | (l & ~m[0]) | (f & ~m[2]);
    endfunction

    // saturating count after a number of loss onsets
    function logic [31:0] f_cnt(input int start, input int pulses);
        return (start + pulses > 15) ? 32'h0000_000f : 32'(start + pulses);
    endfunction

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // generous bound: the sequence needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        results();
    end

    initial begin : main
        logic l, f;
        logic [2:0] m;
        logic [3:0] c;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        los_verdict = 1'b0;
        freq_disqualified = 1'b0;
        err_total = 0;
        samples_checked = 0;
        void'($urandom(7));
        cyc(10);
        rst <= 1'b0;
        @(posedge clk_sys);
        chk("invalid pin", 32'h1, {31'h0, ref_invalid});
        chk("status pin", 32'h1, {31'h0, los_status});
        cyc(3);
        rdc("events", `CDM_OFF_EVENTS, 32'h3, 32'h1);
        rdc("status", `CDM_OFF_STATUS, 32'h3, 32'h0);
        wr(`CDM_OFF_EVENTS, 32'h1);
        rdc("events", `CDM_OFF_EVENTS, 32'h1, 32'h0);
        // a held loss counts once and its event cannot be cleared
        los_verdict <= 1'b1;
        cyc(4);
        rdc("status", `CDM_OFF_STATUS, 32'h3, 32'h3);
        rdc("count", `CDM_OFF_COUNT, 32'hf, 32'h1);
        wr(`CDM_OFF_EVENTS, 32'h1);
        rdc("events", `CDM_OFF_EVENTS, 32'h1, 32'h1);
        los_verdict <= 1'b0;
        cyc(2);
        wr(`CDM_OFF_EVENTS, 32'h1);
        rdc("events", `CDM_OFF_EVENTS, 32'h1, 32'h0);
        // random verdicts against every mask and inhibit setting
        for (int i = 0; i < 16; i++) begin
            l = 1'($urandom);
            f = 1'($urandom);
            m = (i < 8) ? 3'(i) : 3'($urandom);
            wr(`CDM_OFF_CONFIG, {24'h0, m, 5'h0});
            los_verdict <= l;
            freq_disqualified <= f;
            cyc(3);
            rdc("invalid", `CDM_OFF_STATUS, 32'h2, {30'h0, f_invalid(l, f, m), 1'b0});
            chk("barred", {31'h0, m[1]}, {31'h0, ref_barred});
        end
        los_verdict <= 1'b0;
        freq_disqualified <= 1'b0;
        wr(`CDM_OFF_CONFIG, 32'h0);
        cyc(3);
        // preset near the top, then three onsets must saturate
        wr(`CDM_OFF_COUNT, 32'hd);
        rdc("count", `CDM_OFF_COUNT, 32'hf, 32'hd);
        repeat (3) begin
            los_verdict <= 1'b1;
            cyc(2);
            los_verdict <= 1'b0;
            cyc(2);
        end
        rdc("count", `CDM_OFF_COUNT, 32'hf, f_cnt(13, 3));
        wr(`CDM_OFF_COUNT, 32'h0);
        rdc("count", `CDM_OFF_COUNT, 32'hf, 32'h0);
        c = 4'($urandom);
        wr(`CDM_OFF_COUNT, {28'h0, c});
        rdc("count", `CDM_OFF_COUNT, 32'hf, {28'h0, c});
        // limit event at threshold two: above sets, equal does not
        wr(`CDM_OFF_CONFIG, 32'h0000_0200);
        wr(`CDM_OFF_COUNT, 32'h3);
        cyc(2);
        wr(`CDM_OFF_EVENTS, 32'h2);
        rdc("limit", `CDM_OFF_EVENTS, 32'h2, 32'h2);
        wr(`CDM_OFF_COUNT, 32'h2);
        cyc(2);
        wr(`CDM_OFF_EVENTS, 32'h2);
        rdc("limit", `CDM_OFF_EVENTS, 32'h2, 32'h0);
        cyc(2);
        rdc("limit", `CDM_OFF_EVENTS, 32'h2, 32'h0);
        // a cleared limit event sets again once the count is above
        wr(`CDM_OFF_COUNT, 32'h3);
        cyc(2);
        rdc("limit", `CDM_OFF_EVENTS, 32'h2, 32'h2);
        wr(`CDM_OFF_COUNT, 32'h2);
        // gate and soft reset each drop count writes
        for (int k = 1; k < 4; k++) begin
            wr(`CDM_OFF_CONTROL, 32'(k));
            wr(`CDM_OFF_COUNT, 32'h5);
            rdc("count", `CDM_OFF_COUNT, 32'hf, 32'h2);
            rdc("control", `CDM_OFF_CONTROL, 32'h3, 32'(k));
        end
        wr(`CDM_OFF_CONTROL, 32'h0);
        wr(`CDM_OFF_COUNT, 32'h5);
        rdc("count", `CDM_OFF_COUNT, 32'hf, 32'h5);
        xfer(8'h14, 1'b0, 32'h0);
        chk("slverr", 32'h1, {31'h0, rerr});
        results();
    end
endmodule

bind cdm_top cdm_top_chk u_chk (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .los_verdict(los_verdict), .freq_disqualified(freq_disqualified),
    .los_status(los_status), .ref_invalid(ref_invalid), .ref_barred(ref_barred));
